/* src/lvw_cg_pkg.sv */
`default_nettype none
package lvw_cg_pkg;

   // APB address width and register byte offsets.
   localparam int         APB_AW          = 12;
   localparam logic [11:0] OFS_WARN       = 12'h000;
   localparam logic [11:0] OFS_GATE_ONE   = 12'h004;
   localparam logic [11:0] OFS_GATE_TWO   = 12'h008;
   localparam logic [11:0] OFS_INT_STATUS = 12'h00c;
   localparam logic [11:0] OFS_INT_MASK   = 12'h010;

   // Field positions in the warning register.
   localparam int BIT_WARN_FLAG = 7;
   localparam int BIT_WARN_ACK  = 6;
   localparam int BIT_WARN_IE   = 3;

   // Field positions in the first gating register.
   localparam int BIT_MODULO_TIMER = 7;
   localparam int BIT_PULSE_TIMER  = 5;
   localparam int BIT_ADC          = 4;
   localparam int BIT_SERIAL_COMM  = 0;

   // Field positions in the second gating register.
   localparam int BIT_FLASH_REG  = 6;
   localparam int BIT_EXT_IRQ    = 5;
   localparam int BIT_KEYBOARD   = 4;
   localparam int BIT_COMPARATOR = 3;
   localparam int BIT_RTC_BUS    = 2;

   // Implemented bits of each register.
   localparam logic [7:0] GATE_ONE_MASK = 8'hb1;
   localparam logic [7:0] GATE_TWO_MASK = 8'h7c;
   localparam logic [7:0] INT_MASK_BITS = 8'h01;

   // Values after reset: every module clock runs, no warning, all masked.
   localparam logic [7:0] GATE_ONE_RESET = 8'hb1;
   localparam logic [7:0] GATE_TWO_RESET = 8'h7c;
   localparam logic [7:0] INT_RESET      = 8'h00;
   localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

   // Index of each gated module clock on the output vector.
   localparam int CLK_COUNT      = 9;
   localparam int CLK_MODULO     = 0;
   localparam int CLK_PULSE      = 1;
   localparam int CLK_ADC        = 2;
   localparam int CLK_SERIAL     = 3;
   localparam int CLK_FLASH      = 4;
   localparam int CLK_EXT_IRQ    = 5;
   localparam int CLK_KEYBOARD   = 6;
   localparam int CLK_COMPARATOR = 7;
   localparam int CLK_RTC_BUS    = 8;

   // Complete state of the control block.
   typedef struct packed {
      logic        warn_meta;
      logic        warn_sync;
      logic        low_voltage_warning_flag;
      logic        warning_interrupt_enable;
      logic [7:0]  gate_one;
      logic [7:0]  gate_two;
      logic [7:0]  int_status;
      logic [7:0]  int_mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } ctrl_state_t;

endpackage
`default_nettype wire

/* src/clock_gate_cell.sv */
`default_nettype none
module clock_gate_cell
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic en,
   output logic      gclk
);

   logic en_low_r;

   // The enable is retimed on the falling edge, so apart from an asynchronous
   // reset it only changes while the clock is low and the AND below cannot clip a phase.
   always_ff @(negedge clk or negedge rst_n)
   begin
      if (!rst_n)
         en_low_r <= 1'b0;
      else
         en_low_r <= en; // RULE16
   end

   // Gated output; an AND with a low-phase enable is glitch free.
   assign gclk = clk & en_low_r; // RULE16

endmodule
`default_nettype wire

/* src/lv_warning_clock_gating.sv */
// Contract
// RULE1: The flag sets on a live warning, also after reset, and then sticks.
// RULE2: Reading the flag gives one for a live or latched warning, else zero.
// RULE3: An acknowledge write clears the flag only while no warning is live.
// RULE4: With the enable set the flag requests an interrupt; else none is made. The code also requests one from an unmasked status bit.
// RULE5: Bit 7 of gating register one passes or stops the modulo timer clock.
// RULE6: Bit 5 of gating register one passes or stops the pulse timer clock.
// RULE7: Bit 4 of gating register one passes or stops the converter clock.
// RULE8: Bit 0 of gating register one passes or stops the serial clock.
// RULE9: Bit 6 of gating register two gates the flash register clock.
// RULE10: Bit 5 of gating register two gates the external interrupt clock.
// RULE11: Bit 4 of gating register two gates the keyboard interrupt clock.
// RULE12: Bit 3 of gating register two gates all comparators through one gate.
// RULE13: Bit 2 of gating register two gates only the counter's bus clock.
// RULE14: Software disables a peripheral before stopping its clock.
// RULE15: Software re-initialises a peripheral after its clock returns.
// RULE16: Opening or closing a gate never shortens a phase of its clock.
// RULE17: Unimplemented bits read as zero and ignore writes.
`default_nettype none
module lv_warning_clock_gating
(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           pclken,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [lvw_cg_pkg::APB_AW-1:0]  paddr,
   input  wire logic [31:0]                    pwdata,
   input  wire logic [3:0]                     pstrb,
   input  wire logic                           low_voltage_warning,
   output logic [31:0]                         prdata,
   output logic                                pready,
   output logic                                pslverr,
   output logic                                irq,
   output logic [lvw_cg_pkg::CLK_COUNT-1:0]    module_clk
);

   lvw_cg_pkg::ctrl_state_t st_r;
   lvw_cg_pkg::ctrl_state_t st_nxt;

   logic                              setup_phase;
   logic                              access_phase;
   logic                              wr_access;
   logic                              wr_warn;
   logic                              ack_request;
   logic                              ack_clears;
   logic                              flag_seen;
   logic                              addr_mapped;
   logic                              lane0;
   logic [7:0]                        warn_read;
   logic [7:0]                        wbyte;
   logic [lvw_cg_pkg::CLK_COUNT-1:0]  gate_en;

   ////////////////////////////////////////////////////////////////////////
   // Bus phase decode.

   // The slave answers one cycle after setup, so access lasts one cycle.
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable & st_r.pready;
   assign wr_access    = access_phase & pwrite & ~st_r.pslverr;
   assign lane0        = pstrb[0];
   assign wbyte        = pwdata[7:0];
   assign wr_warn      = wr_access & lane0
                         & (paddr == lvw_cg_pkg::OFS_WARN);
   assign ack_request  = wr_warn & wbyte[lvw_cg_pkg::BIT_WARN_ACK];

   // An acknowledge is refused while the warning is still present.
   assign ack_clears   = ack_request & ~st_r.warn_sync; // RULE3

   // Flag as software sees it: latched value or live synchronised level.
   assign flag_seen    = st_r.low_voltage_warning_flag
                         | st_r.warn_sync; // RULE2

   // Address map check; unknown offsets answer with an error.
   always_comb
   begin
      if (paddr == lvw_cg_pkg::OFS_WARN)
         addr_mapped = 1'b1;
      else if (paddr == lvw_cg_pkg::OFS_GATE_ONE)
         addr_mapped = 1'b1;
      else if (paddr == lvw_cg_pkg::OFS_GATE_TWO)
         addr_mapped = 1'b1;
      else if (paddr == lvw_cg_pkg::OFS_INT_STATUS)
         addr_mapped = 1'b1;
      else if (paddr == lvw_cg_pkg::OFS_INT_MASK)
         addr_mapped = 1'b1;
      else
         addr_mapped = 1'b0;
   end

   // Warning register image; the acknowledge bit is write-only.
   always_comb
   begin
      warn_read = 8'h00; // RULE17
      warn_read[lvw_cg_pkg::BIT_WARN_FLAG] = flag_seen; // RULE2
      warn_read[lvw_cg_pkg::BIT_WARN_IE] = st_r.warning_interrupt_enable;
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for the whole block.

   always_comb
   begin
      st_nxt = st_r;
      if (pclken)
      begin
         // Warning comes from the analog comparator, another domain.
         st_nxt.warn_meta = low_voltage_warning;
         st_nxt.warn_sync = st_r.warn_meta;

         // Latch the warning; a live warning beats any acknowledge.
         st_nxt.low_voltage_warning_flag =
            (st_r.low_voltage_warning_flag & ~ack_clears)
            | st_r.warn_sync; // RULE1 RULE3

         // Sticky event bit; a new event wins over a same-cycle clear.
         if (wr_access & lane0 & (paddr == lvw_cg_pkg::OFS_INT_STATUS))
            st_nxt.int_status = st_r.int_status & ~wbyte;
         if (st_r.warn_sync & ~st_r.low_voltage_warning_flag)
            st_nxt.int_status[0] = 1'b1;
         st_nxt.int_status = st_nxt.int_status & lvw_cg_pkg::INT_MASK_BITS;

         // Register writes take effect at the access edge only.
         if (wr_warn)
            st_nxt.warning_interrupt_enable =
               wbyte[lvw_cg_pkg::BIT_WARN_IE];
         if (wr_access & lane0 & (paddr == lvw_cg_pkg::OFS_GATE_ONE))
            st_nxt.gate_one = wbyte & lvw_cg_pkg::GATE_ONE_MASK; // RULE17
         if (wr_access & lane0 & (paddr == lvw_cg_pkg::OFS_GATE_TWO))
            st_nxt.gate_two = wbyte & lvw_cg_pkg::GATE_TWO_MASK; // RULE17
         if (wr_access & lane0 & (paddr == lvw_cg_pkg::OFS_INT_MASK))
            st_nxt.int_mask = wbyte & lvw_cg_pkg::INT_MASK_BITS;

         // Answer in the cycle after setup; data is captured at setup.
         st_nxt.pready = setup_phase;
         if (setup_phase)
         begin
            st_nxt.pslverr = ~addr_mapped;
            st_nxt.prdata  = lvw_cg_pkg::RDATA_RESET;
            if (pwrite)
               st_nxt.prdata = lvw_cg_pkg::RDATA_RESET;
            else if (paddr == lvw_cg_pkg::OFS_WARN)
               st_nxt.prdata[7:0] = warn_read; // RULE2
            else if (paddr == lvw_cg_pkg::OFS_GATE_ONE)
               st_nxt.prdata[7:0] = st_r.gate_one;
            else if (paddr == lvw_cg_pkg::OFS_GATE_TWO)
               st_nxt.prdata[7:0] = st_r.gate_two;
            else if (paddr == lvw_cg_pkg::OFS_INT_STATUS)
               st_nxt.prdata[7:0] = st_r.int_status;
            else if (paddr == lvw_cg_pkg::OFS_INT_MASK)
               st_nxt.prdata[7:0] = st_r.int_mask;
         end
         else if (!psel)
            st_nxt.pslverr = 1'b0;

         // Request while the flag is up and enabled, or on an unmasked status bit.
         st_nxt.irq = (st_r.low_voltage_warning_flag
                       & st_r.warning_interrupt_enable) // RULE4
                      | (|(st_r.int_status & st_r.int_mask));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.

   // Gates reset open so that peripherals work before software acts.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r.warn_meta                <= 1'b0;
         st_r.warn_sync                <= 1'b0;
         st_r.low_voltage_warning_flag <= 1'b0;
         st_r.warning_interrupt_enable <= 1'b0;
         st_r.gate_one                 <= lvw_cg_pkg::GATE_ONE_RESET;
         st_r.gate_two                 <= lvw_cg_pkg::GATE_TWO_RESET;
         st_r.int_status               <= lvw_cg_pkg::INT_RESET;
         st_r.int_mask                 <= lvw_cg_pkg::INT_RESET;
         st_r.prdata                   <= lvw_cg_pkg::RDATA_RESET;
         st_r.pready                   <= 1'b0;
         st_r.pslverr                  <= 1'b0;
         st_r.irq                      <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Bus and interrupt outputs come straight from the state register.
   assign prdata  = st_r.prdata;
   assign pready  = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign irq     = st_r.irq;

   ////////////////////////////////////////////////////////////////////////
   // Clock gates.

   // Each gating bit drives exactly one gate cell.
   always_comb
   begin
      gate_en = '0;
      gate_en[lvw_cg_pkg::CLK_MODULO] =
         st_r.gate_one[lvw_cg_pkg::BIT_MODULO_TIMER]; // RULE5
      gate_en[lvw_cg_pkg::CLK_PULSE] =
         st_r.gate_one[lvw_cg_pkg::BIT_PULSE_TIMER]; // RULE6
      gate_en[lvw_cg_pkg::CLK_ADC] =
         st_r.gate_one[lvw_cg_pkg::BIT_ADC]; // RULE7
      gate_en[lvw_cg_pkg::CLK_SERIAL] =
         st_r.gate_one[lvw_cg_pkg::BIT_SERIAL_COMM]; // RULE8
      gate_en[lvw_cg_pkg::CLK_FLASH] =
         st_r.gate_two[lvw_cg_pkg::BIT_FLASH_REG]; // RULE9
      gate_en[lvw_cg_pkg::CLK_EXT_IRQ] =
         st_r.gate_two[lvw_cg_pkg::BIT_EXT_IRQ]; // RULE10
      gate_en[lvw_cg_pkg::CLK_KEYBOARD] =
         st_r.gate_two[lvw_cg_pkg::BIT_KEYBOARD]; // RULE11
      // One shared comparator clock feeds every comparator instance.
      gate_en[lvw_cg_pkg::CLK_COMPARATOR] =
         st_r.gate_two[lvw_cg_pkg::BIT_COMPARATOR]; // RULE12
      // Only the counter's bus clock is gated here; its reference and
      // low-power oscillator clocks bypass this block entirely.
      gate_en[lvw_cg_pkg::CLK_RTC_BUS] =
         st_r.gate_two[lvw_cg_pkg::BIT_RTC_BUS]; // RULE13
   end

   // A stopped peripheral keeps stale state; software must reload it.
   genvar gi;
   generate
      for (gi = 0; gi < lvw_cg_pkg::CLK_COUNT; gi++)
      begin : g_gate
         clock_gate_cell u_gate
         (
            .clk   (pclk),
            .rst_n (presetn),
            .en    (gate_en[gi]),
            .gclk  (module_clk[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence ack_free_s;
      pclken && ack_request && !st_r.warn_sync;
   endsequence

   sequence ack_busy_s;
      pclken && ack_request && st_r.warn_sync;
   endsequence

   a_flag_set_on: assert property ( // RULE1
      pclken && st_r.warn_sync |=> st_r.low_voltage_warning_flag)
      else $error("Warning flag did not set on a live warning.");

   a_flag_holds_on: assert property ( // RULE1
      pclken && st_r.low_voltage_warning_flag && !ack_request
      |=> st_r.low_voltage_warning_flag)
      else $error("Warning flag dropped without an acknowledge.");

   a_flag_read_value: assert property ( // RULE2
      pclken && setup_phase && !pwrite && paddr == lvw_cg_pkg::OFS_WARN
      |=> prdata[7] == $past(flag_seen) && prdata[6] == 1'b0)
      else $error("Warning register read returned a wrong flag.");

   a_ack_clears_flag: assert property ( // RULE3
      ack_free_s |=> !st_r.low_voltage_warning_flag)
      else $error("Acknowledge failed to clear an idle warning.");

   a_ack_refused_live: assert property ( // RULE3
      ack_busy_s |=> st_r.low_voltage_warning_flag)
      else $error("Acknowledge cleared a live warning.");

   a_irq_requested: assert property ( // RULE4
      pclken && st_r.low_voltage_warning_flag
      && st_r.warning_interrupt_enable |=> irq)
      else $error("Enabled warning flag did not raise the interrupt.");

   a_irq_quiet_off: assert property ( // RULE4
      pclken && !(st_r.low_voltage_warning_flag
      && st_r.warning_interrupt_enable)
      && !(|(st_r.int_status & st_r.int_mask)) |=> !irq)
      else $error("Interrupt raised with nothing enabled.");

   a_gate_write_one: assert property ( // RULE5 RULE17
      pclken && wr_access && lane0 && paddr == lvw_cg_pkg::OFS_GATE_ONE
      |=> st_r.gate_one == ($past(wbyte) & lvw_cg_pkg::GATE_ONE_MASK))
      else $error("First gating register did not take the write.");

   a_gate_write_two: assert property ( // RULE9 RULE17
      pclken && wr_access && lane0 && paddr == lvw_cg_pkg::OFS_GATE_TWO
      |=> st_r.gate_two == ($past(wbyte) & lvw_cg_pkg::GATE_TWO_MASK))
      else $error("Second gating register did not take the write.");

   a_unused_bits_zero: assert property ( // RULE17
      (st_r.gate_one & ~lvw_cg_pkg::GATE_ONE_MASK) == 8'h00
      && (st_r.gate_two & ~lvw_cg_pkg::GATE_TWO_MASK) == 8'h00)
      else $error("An unimplemented gating bit became set.");

   // Sampled on the falling edge the gated clock shows its high phase, so
   // one cycle after a gate closes the clock must read low there.
   a_gate_stops_clk: assert property ( // RULE16 RULE7
      @(negedge pclk) disable iff (!presetn)
      !gate_en[lvw_cg_pkg::CLK_ADC] |=> !module_clk[lvw_cg_pkg::CLK_ADC])
      else $error("Converter clock ran while its gate was closed.");

   // Every gated clock must follow its own bit; an open gate that does not
   // pass the clock would starve the module behind it.
   for (genvar ai = 0; ai < lvw_cg_pkg::CLK_COUNT; ai++)
   begin : g_gate_chk
      a_gate_tracks_bit: assert property ( // RULE5 RULE13 RULE16
         @(negedge pclk) disable iff (!presetn)
         1'b1 |=> module_clk[ai] == $past(gate_en[ai]))
         else $error("A module clock did not follow its gate bit.");
   end

   // A setup is answered in the very next cycle and the answer is a pulse.
   a_ready_after_setup: assert property (
      pclken && setup_phase |=> pready)
      else $error("A setup cycle was not answered in the next cycle.");

   a_ready_one_pulse: assert property (
      pclken && pready && penable |=> !pready)
      else $error("The ready pulse stood for more than one cycle.");

   // An unmapped offset answers with an error and reads back zero.
   a_unmapped_refused: assert property (
      pclken && setup_phase && !addr_mapped
      |=> pslverr && prdata == lvw_cg_pkg::RDATA_RESET)
      else $error("An unmapped offset was answered without an error.");

   // The status bit is sticky: only a write to its register may clear it.
   a_status_sticky: assert property (
      pclken && st_r.int_status[0]
      && !(wr_access && lane0 && paddr == lvw_cg_pkg::OFS_INT_STATUS)
      |=> st_r.int_status[0])
      else $error("The event status bit cleared without a write.");

endmodule
`default_nettype wire

/* tb/lv_warning_clock_gating_tb_top.sv */
`default_nettype none
// Counts every comparison and reports a mismatch at once.
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("ERROR at %0t: got %h, expected %h", $time, got, exp); \
      end \
   end

module lv_warning_clock_gating_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        pclk;
   logic        presetn;
   logic        pclken;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        low_voltage_warning;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [8:0]  module_clk;
   logic [31:0] rd;
   logic        er;
   int          n_errors;
   int          tests_run;
   int          cnt [9];

   // Gate bit of each module clock, in the order of the output vector.
   localparam int GATE_BIT [9] = '{lvw_cg_pkg::BIT_MODULO_TIMER,
      lvw_cg_pkg::BIT_PULSE_TIMER, lvw_cg_pkg::BIT_ADC,
      lvw_cg_pkg::BIT_SERIAL_COMM, lvw_cg_pkg::BIT_FLASH_REG,
      lvw_cg_pkg::BIT_EXT_IRQ, lvw_cg_pkg::BIT_KEYBOARD,
      lvw_cg_pkg::BIT_COMPARATOR, lvw_cg_pkg::BIT_RTC_BUS};

   lv_warning_clock_gating u_dut
   (
      .pclk                (pclk),
      .presetn             (presetn),
      .pclken              (pclken),
      .psel                (psel),
      .penable             (penable),
      .pwrite              (pwrite),
      .paddr               (paddr),
      .pwdata              (pwdata),
      .pstrb               (4'hf),
      .low_voltage_warning (low_voltage_warning),
      .prdata              (prdata),
      .pready              (pready),
      .pslverr             (pslverr),
      .irq                 (irq),
      .module_clk          (module_clk)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus clock at 20 MHz.
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Each gated clock is counted and its phases measured; a reset cuts a
   // phase short on purpose, so phases ending in reset are not judged.
   for (genvar g = 0; g < 9; g++)
   begin : g_mon
      time tr = 0;
      time tf = 0;
      always @(posedge module_clk[g])
      begin
         if (tf != 0 && presetn === 1'b1)
            `CHK(($time - tf) >= 25, 1'b1)
         tr = $time;
         cnt[g]++;
      end
      always @(negedge module_clk[g])
      begin
         if (presetn === 1'b1)
            `CHK(($time - tr) == 25, 1'b1)
         tf = $time;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One APB transfer; read data and error are taken at the ready edge.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      begin
         @(posedge pclk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= d;
         @(posedge pclk);
         penable <= 1'b1;
         // No cycle count is assumed; only the watchdog ends a hung wait.
         do
            @(posedge pclk);
         while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Waits whole cycles and ends on a falling edge, where outputs are settled.
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   task automatic do_reset;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset values, read-only and unimplemented bits, unmapped addresses.
   task automatic t_regs;
      apb(1'b0, lvw_cg_pkg::OFS_GATE_ONE, 32'h0);
      `CHK(rd, 32'h0000_00b1)
      apb(1'b0, lvw_cg_pkg::OFS_GATE_TWO, 32'h0);
      `CHK(rd, 32'h0000_007c)
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'hffff_ffb7);
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0000)
      apb(1'b1, lvw_cg_pkg::OFS_GATE_TWO, 32'hffff_ffff);
      apb(1'b0, lvw_cg_pkg::OFS_GATE_TWO, 32'h0);
      `CHK(rd, 32'h0000_007c)
      apb(1'b1, 12'h020, 32'h0000_00ff);
      `CHK(er, 1'b1)
      apb(1'b0, 12'h014, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
   endtask

   // Closing one gate at a time must stop only that module clock.
   task automatic t_gates;
      int          snap [9];
      logic [11:0] a;
      logic [7:0]  rv;
      logic [7:0]  v;
      for (int k = 0; k < 9; k++)
      begin
         a = (k < 4) ? lvw_cg_pkg::OFS_GATE_ONE : lvw_cg_pkg::OFS_GATE_TWO;
         rv = (k < 4) ? 8'hb1 : 8'h7c;
         v = rv & ~(8'h01 << GATE_BIT[k]);
         apb(1'b1, a, {24'h0, v});
         apb(1'b0, a, 32'h0);
         `CHK(rd, {24'h0, v})
         cyc(3);
         snap = cnt;
         cyc(8);
         for (int j = 0; j < 9; j++)
            `CHK((cnt[j] - snap[j] >= 7) == (j != k), 1'b1)
         apb(1'b1, a, {24'h0, rv});
      end
   endtask

   // Warning flag: sticky, acknowledge only when clear, interrupt enable.
   task automatic t_warning;
      @(posedge pclk);
      low_voltage_warning <= 1'b1;
      cyc(5);
      `CHK(irq, 1'b0)
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0080)
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'h0000_0040);
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0080)
      low_voltage_warning <= 1'b0;
      cyc(5);
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0080)
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'h0000_0008);
      cyc(2);
      `CHK(irq, 1'b1)
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'h0000_0048);
      cyc(2);
      `CHK(irq, 1'b0)
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0008)
      // The latched event also stands in the status register until cleared.
      apb(1'b0, lvw_cg_pkg::OFS_INT_STATUS, 32'h0);
      `CHK(rd, 32'h0000_0001)
      apb(1'b1, lvw_cg_pkg::OFS_INT_MASK, 32'h0000_0001);
      cyc(2);
      `CHK(irq, 1'b1)
      apb(1'b1, lvw_cg_pkg::OFS_INT_STATUS, 32'h0000_0001);
      cyc(2);
      `CHK(irq, 1'b0)
      apb(1'b0, lvw_cg_pkg::OFS_INT_STATUS, 32'h0);
      `CHK(rd, 32'h0000_0000)
   endtask

   // A warning present across a reset is flagged, and gates reopen.
   task automatic t_reset_warn;
      apb(1'b1, lvw_cg_pkg::OFS_GATE_ONE, 32'h0);
      @(posedge pclk);
      low_voltage_warning <= 1'b1;
      do_reset;
      cyc(6);
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0080)
      apb(1'b0, lvw_cg_pkg::OFS_GATE_ONE, 32'h0);
      `CHK(rd, 32'h0000_00b1)
      low_voltage_warning <= 1'b0;
      cyc(5);
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'h0000_0040);
      apb(1'b0, lvw_cg_pkg::OFS_WARN, 32'h0);
      `CHK(rd, 32'h0000_0000)
   endtask

   // A low clock enable freezes the block; a warning waits until it rises.
   task automatic t_freeze;
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'h0000_0008);
      @(posedge pclk);
      pclken <= 1'b0;
      low_voltage_warning <= 1'b1;
      cyc(6);
      `CHK(irq, 1'b0)
      @(posedge pclk);
      pclken <= 1'b1;
      cyc(6);
      `CHK(irq, 1'b1)
      @(posedge pclk);
      low_voltage_warning <= 1'b0;
      cyc(5);
      apb(1'b1, lvw_cg_pkg::OFS_WARN, 32'h0000_0040);
      cyc(2);
      `CHK(irq, 1'b0)
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      presetn = 1'b0;
      pclken = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      low_voltage_warning = 1'b0;
      do_reset;
      t_regs;
      t_gates;
      t_warning;
      t_reset_warn;
      t_freeze;
      print_verdict;
   end

   // The whole run takes about 350 cycles; the limit of 10,000 cycles leaves wide margin.
   initial
   begin
      #500000;
      n_errors++;
      print_verdict;
   end
endmodule
`default_nettype wire
